// ===== verilog/filter_pkg.sv
package filter_pkg;
    // =========================================================
    // Sizes
    localparam int NPORT = 8;
    localparam int PIDX_W = 3;
    localparam int MAC_W = 48;
    localparam int VLAN_W = 12;
    localparam int AGE_W = 14;
    localparam int COLL_W = 7;
    localparam int BC_W = 16;

    // =========================================================
    // Timing
    localparam int CLK_HZ = 40_000_000;
    localparam int TICK_S = 1;
    localparam int TICK_CYC = CLK_HZ * TICK_S;
    localparam logic [AGE_W-1:0] AGE_MIN_S = 14'h000a;
    localparam logic [AGE_W-1:0] AGE_MAX_S = 14'h270f;
    localparam logic [COLL_W-1:0] COLL_LIMIT = 7'h3d;

    // =========================================================
    // Spanning-tree port states
    localparam logic [1:0] STP_BLOCK = 2'h0;
    localparam logic [1:0] STP_LISTEN = 2'h1;
    localparam logic [1:0] STP_LEARN = 2'h2;
    localparam logic [1:0] STP_FWD = 2'h3;

    // =========================================================
    // Types
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_SCAN = 4'h2,
        ST_DONE = 4'h4,
        ST_AGE = 4'h8
    } state_t;

    typedef struct packed {
        logic [MAC_W-1:0] src;
        logic [MAC_W-1:0] dst;
        logic [PIDX_W-1:0] port;
        logic [VLAN_W-1:0] vlan;
    } frame_t;

    typedef struct packed {
        logic drop;
        logic flood;
        logic [NPORT-1:0] mask;
    } verdict_t;

    typedef struct packed {
        logic valid;
        logic fixed;
        logic [MAC_W-1:0] mac;
        logic [PIDX_W-1:0] port;
        logic [VLAN_W-1:0] vlan;
        logic [AGE_W-1:0] age;
    } entry_t;

    localparam int ENTRY_W = $bits(entry_t);
endpackage

// ===== verilog/table_mem.sv
module table_mem
    import filter_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int AW = $clog2(DEPTH)
)(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire entry_t wdata,
    // Read port
    input wire logic [AW-1:0] raddr,
    output entry_t rdata_ff
);
    entry_t mem [DEPTH];
    logic [DEPTH-1:0] live_ff;
    logic [DEPTH-1:0] nxt_live;
    entry_t nxt_rdata;

    // =========================================================
    // Valid bits reset so the table starts empty
    always_comb
    begin
        nxt_live = live_ff;
        if (we)
        begin
            nxt_live[waddr] = wdata.valid;
        end
        nxt_rdata = mem[raddr];
        nxt_rdata.valid = live_ff[raddr];
    end

    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            live_ff <= '0;
            rdata_ff <= '0;
        end
        else
        begin
            live_ff <= nxt_live;
            rdata_ff <= nxt_rdata;
        end
    end
endmodule // table_mem

// ===== verilog/address_learning_filter_engine.sv
// Function
// - Known destination goes only to its learned port.
// - Source addresses are learned with their port as dynamic entries.
// - Dynamic entries older than the aging interval are removed.
// - Aging interval spans 10 to 9999 seconds; management stays inside.
// - Lookup miss floods the frame to all forwarding ports except the arrival port.
// - Destination learned on the arrival port means discard.
// - Source or destination matching a filter entry means discard.
// - Destination in a different VLAN means discard.
// - Ports not forwarding in the spanning tree carry no frames.
// - More than sixty-one collisions partition the port, any speed.
// - Every link toggle raises a link-change event.
// - Learning-to-forwarding or forwarding-to-blocking on a port with port_cfg set raises topology change, unless new root.
// - Becoming spanning-tree root raises a new-root event promptly.
// - Crossing broadcast rising or falling threshold raises a storm event.
module address_learning_filter_engine
    import filter_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int AW = $clog2(DEPTH),
    parameter int TICK_CYCLES = TICK_CYC
)(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Frame lookup
    input wire logic frame_valid,
    input wire frame_t frame,
    output logic frame_ready_ff,
    output logic verdict_valid_ff,
    output verdict_t verdict_ff,
    // Filter entry programming
    input wire logic flt_wr,
    input wire logic [AW-1:0] flt_idx,
    input wire logic [MAC_W-1:0] flt_mac,
    input wire logic [VLAN_W-1:0] flt_vlan,
    input wire logic flt_keep,
    output logic flt_done_ff,
    // Configuration
    input wire logic [AGE_W-1:0] age_secs,
    input wire logic [NPORT-1:0] port_cfg,
    input wire logic [NPORT-1:0][1:0] stp_state,
    input wire logic is_root,
    input wire logic [BC_W-1:0] bc_rise,
    input wire logic [BC_W-1:0] bc_fall,
    // Port status from the MACs
    input wire logic [NPORT-1:0] link_up,
    input wire logic [NPORT-1:0] coll,
    input wire logic [NPORT-1:0] bcast,
    // Events to management
    output logic [NPORT-1:0] partition_ff,
    output logic [NPORT-1:0] part_evt_ff,
    output logic [NPORT-1:0] link_evt_ff,
    output logic topo_evt_ff,
    output logic root_evt_ff,
    output logic [NPORT-1:0] storm_ff,
    output logic [NPORT-1:0] storm_evt_ff
);
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    function automatic logic [NPORT-1:0] port_bit(input logic [PIDX_W-1:0] p);
        port_bit = '0;
        port_bit[p] = 1'b1;
    endfunction

    // =========================================================
    // Lookup, learning and aging engine
    state_t state_ff, nxt_state;
    logic [AW-1:0] idx_ff, nxt_idx, chk_idx_ff, nxt_chk_idx;
    logic issued_ff, nxt_issued, chk_ff, nxt_chk;
    frame_t fr_ff, nxt_fr;
    logic dst_hit_ff, nxt_dst_hit, dst_fixed_ff, nxt_dst_fixed;
    entry_t dst_ent_ff, nxt_dst_ent;
    logic src_hit_ff, nxt_src_hit, src_fixed_ff, nxt_src_fixed;
    logic [AW-1:0] src_idx_ff, nxt_src_idx, free_idx_ff, nxt_free_idx;
    logic free_ok_ff, nxt_free_ok, age_pend_ff, nxt_pend;
    logic nxt_vvalid, nxt_flt_done;
    verdict_t nxt_verdict;
    logic [AGE_W-1:0] age_lim_ff, nxt_lim;
    logic tick_ff;
    logic we;
    logic [AW-1:0] waddr;
    entry_t wdata, rdata;
    logic [NPORT-1:0] fwd_ports;
    logic last_chk;

    table_mem #(.DEPTH(DEPTH), .AW(AW)) u_table (
        .clk(clk),
        .nrst(nrst),
        .we(we),
        .waddr(waddr),
        .wdata(wdata),
        .raddr(idx_ff),
        .rdata_ff(rdata)
    );

    always_comb
    begin
        for (int p = 0; p < NPORT; p++)
        begin
            fwd_ports[p] = (stp_state[p] == STP_FWD);
        end
        last_chk = chk_ff && (chk_idx_ff == LAST);
        nxt_state = state_ff;
        nxt_idx = idx_ff;
        nxt_issued = issued_ff;
        nxt_chk = 1'b0;
        nxt_chk_idx = idx_ff;
        nxt_fr = fr_ff;
        nxt_dst_hit = dst_hit_ff;
        nxt_dst_fixed = dst_fixed_ff;
        nxt_dst_ent = dst_ent_ff;
        nxt_src_hit = src_hit_ff;
        nxt_src_fixed = src_fixed_ff;
        nxt_src_idx = src_idx_ff;
        nxt_free_ok = free_ok_ff;
        nxt_free_idx = free_idx_ff;
        nxt_pend = age_pend_ff | tick_ff;
        nxt_vvalid = 1'b0;
        nxt_verdict = verdict_ff;
        nxt_flt_done = 1'b0;
        we = 1'b0;
        waddr = chk_idx_ff;
        wdata = rdata;
        // Walk the table one entry per cycle
        if ((state_ff == ST_SCAN || state_ff == ST_AGE) && !issued_ff)
        begin
            nxt_chk = 1'b1;
            if (idx_ff == LAST)
            begin
                nxt_issued = 1'b1;
            end
            else
            begin
                nxt_idx = idx_ff + 1'b1;
            end
        end
        case (state_ff)
            ST_IDLE:
            begin
                nxt_idx = '0;
                nxt_issued = 1'b0;
                if (frame_valid)
                begin
                    nxt_fr = frame;
                    nxt_dst_hit = 1'b0;
                    nxt_dst_fixed = 1'b0;
                    nxt_src_hit = 1'b0;
                    nxt_src_fixed = 1'b0;
                    nxt_free_ok = 1'b0;
                    nxt_state = ST_SCAN;
                end
                else if (flt_wr)
                begin
                    we = 1'b1;
                    waddr = flt_idx;
                    wdata.valid = flt_keep;
                    wdata.fixed = 1'b1;
                    wdata.mac = flt_mac;
                    wdata.port = '0;
                    wdata.vlan = flt_vlan;
                    wdata.age = '0;
                    nxt_flt_done = 1'b1;
                end
                else if (age_pend_ff)
                begin
                    nxt_pend = tick_ff;
                    nxt_state = ST_AGE;
                end
            end
            ST_SCAN:
            begin
                if (chk_ff && rdata.valid)
                begin
                    if (rdata.mac == fr_ff.dst)
                    begin
                        if (rdata.fixed)
                        begin
                            nxt_dst_fixed = 1'b1;
                        end
                        else
                        begin
                            nxt_dst_hit = 1'b1;
                            nxt_dst_ent = rdata;
                        end
                    end
                    if (rdata.mac == fr_ff.src)
                    begin
                        if (rdata.fixed)
                        begin
                            nxt_src_fixed = 1'b1;
                        end
                        else
                        begin
                            nxt_src_hit = 1'b1;
                            nxt_src_idx = chk_idx_ff;
                        end
                    end
                end
                if (chk_ff && !rdata.valid && !free_ok_ff)
                begin
                    nxt_free_ok = 1'b1;
                    nxt_free_idx = chk_idx_ff;
                end
                if (last_chk)
                begin
                    nxt_state = ST_DONE;
                end
            end
            ST_DONE:
            begin
                nxt_vvalid = 1'b1;
                nxt_verdict = '0;
                nxt_verdict.drop = 1'b1;
                if (src_fixed_ff || dst_fixed_ff)
                begin
                    nxt_verdict.drop = 1'b1;
                end
                else if (!fwd_ports[fr_ff.port])
                begin
                    nxt_verdict.drop = 1'b1;
                end
                else if (dst_hit_ff)
                begin
                    if (dst_ent_ff.port != fr_ff.port && dst_ent_ff.vlan == fr_ff.vlan
                        && fwd_ports[dst_ent_ff.port])
                    begin
                        nxt_verdict.drop = 1'b0;
                        nxt_verdict.mask = port_bit(dst_ent_ff.port);
                    end
                end
                else
                begin
                    nxt_verdict.drop = 1'b0;
                    nxt_verdict.flood = 1'b1;
                    nxt_verdict.mask = fwd_ports & ~port_bit(fr_ff.port);
                end
                // Learn or refresh the sender; filter entries stay untouched
                if ((stp_state[fr_ff.port] == STP_LEARN || fwd_ports[fr_ff.port])
                    && !src_fixed_ff && (src_hit_ff || free_ok_ff))
                begin
                    we = 1'b1;
                    waddr = src_hit_ff ? src_idx_ff : free_idx_ff;
                    wdata.valid = 1'b1;
                    wdata.fixed = 1'b0;
                    wdata.mac = fr_ff.src;
                    wdata.port = fr_ff.port;
                    wdata.vlan = fr_ff.vlan;
                    wdata.age = '0;
                end
                nxt_state = ST_IDLE;
            end
            ST_AGE:
            begin
                if (chk_ff && rdata.valid && !rdata.fixed)
                begin
                    we = 1'b1;
                    wdata.age = rdata.age + 1'b1;
                    if (rdata.age >= age_lim_ff)
                    begin
                        wdata.valid = 1'b0;
                    end
                end
                if (last_chk)
                begin
                    nxt_state = ST_IDLE;
                end
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_ff <= ST_IDLE;
            frame_ready_ff <= 1'b1;
            idx_ff <= '0;
            issued_ff <= 1'b0;
            chk_ff <= 1'b0;
            chk_idx_ff <= '0;
            fr_ff <= '0;
            dst_hit_ff <= 1'b0;
            dst_fixed_ff <= 1'b0;
            dst_ent_ff <= '0;
            src_hit_ff <= 1'b0;
            src_fixed_ff <= 1'b0;
            src_idx_ff <= '0;
            free_ok_ff <= 1'b0;
            free_idx_ff <= '0;
            age_pend_ff <= 1'b0;
            verdict_valid_ff <= 1'b0;
            verdict_ff <= '0;
            flt_done_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            frame_ready_ff <= (nxt_state == ST_IDLE);
            idx_ff <= nxt_idx;
            issued_ff <= nxt_issued;
            chk_ff <= nxt_chk;
            chk_idx_ff <= nxt_chk_idx;
            fr_ff <= nxt_fr;
            dst_hit_ff <= nxt_dst_hit;
            dst_fixed_ff <= nxt_dst_fixed;
            dst_ent_ff <= nxt_dst_ent;
            src_hit_ff <= nxt_src_hit;
            src_fixed_ff <= nxt_src_fixed;
            src_idx_ff <= nxt_src_idx;
            free_ok_ff <= nxt_free_ok;
            free_idx_ff <= nxt_free_idx;
            age_pend_ff <= nxt_pend;
            verdict_valid_ff <= nxt_vvalid;
            verdict_ff <= nxt_verdict;
            flt_done_ff <= nxt_flt_done;
        end
    end

    // =========================================================
    // Tick, aging limit and port events
    logic [TW-1:0] tick_cnt_ff, nxt_tick_cnt;
    logic nxt_tick, root_q_ff, nxt_topo, nxt_root_evt;
    logic [NPORT-1:0] link_q_ff, nxt_part, nxt_part_evt, nxt_link_evt, nxt_storm, nxt_storm_evt;
    logic [NPORT-1:0][1:0] stp_q_ff;
    logic [NPORT-1:0][COLL_W-1:0] coll_cnt_ff, nxt_coll_cnt;
    logic [NPORT-1:0][BC_W-1:0] bc_cnt_ff, nxt_bc_cnt;

    always_comb
    begin
        nxt_tick = (tick_cnt_ff == TW'(TICK_CYCLES - 1));
        nxt_tick_cnt = nxt_tick ? '0 : tick_cnt_ff + 1'b1;
        nxt_lim = age_secs;
        if (age_secs < AGE_MIN_S)
        begin
            nxt_lim = AGE_MIN_S;
        end
        else if (age_secs > AGE_MAX_S)
        begin
            nxt_lim = AGE_MAX_S;
        end
        nxt_root_evt = is_root && !root_q_ff;
        nxt_topo = 1'b0;
        for (int p = 0; p < NPORT; p++)
        begin
            nxt_link_evt[p] = link_up[p] != link_q_ff[p];
            if (port_cfg[p] && ((stp_q_ff[p] == STP_LEARN && stp_state[p] == STP_FWD)
                || (stp_q_ff[p] == STP_FWD && stp_state[p] == STP_BLOCK)))
            begin
                nxt_topo = !nxt_root_evt;
            end
            nxt_coll_cnt[p] = coll_cnt_ff[p];
            nxt_part[p] = partition_ff[p];
            nxt_part_evt[p] = 1'b0;
            if (!link_up[p])
            begin
                nxt_coll_cnt[p] = '0;
                nxt_part[p] = 1'b0;
            end
            else if (coll[p] && !partition_ff[p])
            begin
                nxt_coll_cnt[p] = coll_cnt_ff[p] + 1'b1;
                if (coll_cnt_ff[p] >= COLL_LIMIT)
                begin
                    nxt_part[p] = 1'b1;
                    nxt_part_evt[p] = 1'b1;
                end
            end
            nxt_bc_cnt[p] = (bcast[p] && bc_cnt_ff[p] != '1) ? bc_cnt_ff[p] + 1'b1 : bc_cnt_ff[p];
            nxt_storm[p] = storm_ff[p];
            nxt_storm_evt[p] = 1'b0;
            if (tick_ff)
            begin
                nxt_bc_cnt[p] = '0;
                if (!storm_ff[p] && bc_cnt_ff[p] >= bc_rise)
                begin
                    nxt_storm[p] = 1'b1;
                    nxt_storm_evt[p] = 1'b1;
                end
                else if (storm_ff[p] && bc_cnt_ff[p] <= bc_fall)
                begin
                    nxt_storm[p] = 1'b0;
                    nxt_storm_evt[p] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tick_cnt_ff <= '0;
            tick_ff <= 1'b0;
            age_lim_ff <= AGE_MIN_S;
            root_q_ff <= 1'b0;
            link_q_ff <= '0;
            stp_q_ff <= '0;
            coll_cnt_ff <= '0;
            bc_cnt_ff <= '0;
            partition_ff <= '0;
            part_evt_ff <= '0;
            link_evt_ff <= '0;
            topo_evt_ff <= 1'b0;
            root_evt_ff <= 1'b0;
            storm_ff <= '0;
            storm_evt_ff <= '0;
        end
        else
        begin
            tick_cnt_ff <= nxt_tick_cnt;
            tick_ff <= nxt_tick;
            age_lim_ff <= nxt_lim;
            root_q_ff <= is_root;
            link_q_ff <= link_up;
            stp_q_ff <= stp_state;
            coll_cnt_ff <= nxt_coll_cnt;
            bc_cnt_ff <= nxt_bc_cnt;
            partition_ff <= nxt_part;
            part_evt_ff <= nxt_part_evt;
            link_evt_ff <= nxt_link_evt;
            topo_evt_ff <= nxt_topo;
            root_evt_ff <= nxt_root_evt;
            storm_ff <= nxt_storm;
            storm_evt_ff <= nxt_storm_evt;
        end
    end

    // =========================================================
    // Checks
    unicast_onehot_a: assert property (@(posedge clk) disable iff (!nrst)
        verdict_valid_ff && !verdict_ff.drop && !verdict_ff.flood |-> $onehot(verdict_ff.mask))
        else $error("unicast verdict not one port");
    flood_excl_a: assert property (@(posedge clk) disable iff (!nrst)
        verdict_valid_ff && verdict_ff.flood |-> (verdict_ff.mask & port_bit(fr_ff.port)) == '0)
        else $error("flood includes ingress port");
    same_port_a: assert property (@(posedge clk) disable iff (!nrst)
        state_ff == ST_DONE && dst_hit_ff && dst_ent_ff.port == fr_ff.port |=> verdict_ff.drop)
        else $error("same-port frame forwarded");
    filter_drop_a: assert property (@(posedge clk) disable iff (!nrst)
        state_ff == ST_DONE && (src_fixed_ff || dst_fixed_ff) |=> verdict_valid_ff && verdict_ff.drop)
        else $error("filtered address forwarded");
    stp_block_a: assert property (@(posedge clk) disable iff (!nrst)
        verdict_valid_ff |-> (verdict_ff.mask & ~$past(fwd_ports)) == '0)
        else $error("frame sent to blocked port");
    age_range_a: assert property (@(posedge clk) disable iff (!nrst)
        age_lim_ff >= AGE_MIN_S && age_lim_ff <= AGE_MAX_S)
        else $error("aging limit out of range");
    partition_a: assert property (@(posedge clk) disable iff (!nrst)
        $rose(partition_ff[0]) |-> part_evt_ff[0] && $past(coll_cnt_ff[0]) == COLL_LIMIT)
        else $error("partition at wrong count");
    link_evt_a: assert property (@(posedge clk) disable iff (!nrst)
        link_up[0] != $past(link_up[0]) |=> link_evt_ff[0])
        else $error("link toggle without event");
    root_evt_a: assert property (@(posedge clk) disable iff (!nrst)
        $rose(is_root) |=> root_evt_ff ##1 !root_evt_ff)
        else $error("new root event missing");
    topo_root_a: assert property (@(posedge clk) disable iff (!nrst)
        $rose(is_root) |=> !topo_evt_ff)
        else $error("topology event with new root");
    storm_evt_a: assert property (@(posedge clk) disable iff (!nrst)
        storm_evt_ff[0] |-> storm_ff[0] != $past(storm_ff[0]) && $past(tick_ff))
        else $error("storm event without crossing");
endmodule // address_learning_filter_engine

// ===== testbench/mac_stub.sv
module mac_stub
    import filter_pkg::*;
(
    // Clock
    input wire logic clk,
    // Commands from the bench
    input wire logic [NPORT-1:0] link_req,
    input wire logic [PIDX_W-1:0] coll_port,
    input wire logic [7:0] coll_n,
    input wire logic coll_go,
    // Port status toward the engine
    output logic [NPORT-1:0] link_up,
    output logic [NPORT-1:0] coll
);
    timeunit 1ns;
    timeprecision 1ps;
    int left = 0;
    initial link_up = '0;
    initial coll = '0;
    // =========================================================
    // One collision pulse every other cycle
    always @(posedge clk)
    begin
        link_up <= link_req;
        coll <= '0;
        if (coll_go)
            left <= coll_n;
        else if (left > 0 && coll == '0)
        begin
            coll[coll_port] <= 1'b1;
            left <= left - 1;
        end
    end
endmodule // mac_stub

// ===== testbench/test_address_learning_filter_engine.sv
module test_address_learning_filter_engine import filter_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, nrst, frame_valid, flt_wr, is_root, coll_go, at, ar, flt_keep;
    logic frame_ready_ff, verdict_valid_ff, flt_done_ff, topo_evt_ff, root_evt_ff;
    frame_t frame;
    verdict_t verdict_ff;
    logic [2:0] coll_port, flt_idx;
    logic [7:0] coll_n;
    logic [AGE_W-1:0] age_secs;
    logic [NPORT-1:0] port_cfg, link_up, link_req, coll, partition_ff, part_evt_ff, al, ap;
    logic [NPORT-1:0] link_evt_ff, storm_ff, storm_evt_ff, bcast, as;
    logic [NPORT-1:0][1:0] stp_state;
    int fails = 0, comparisons = 0, seed = 46, cyc = 0;
    int lport[longint];
    int lvlan[longint];
    bit filt[longint];
    logic [MAC_W-1:0] m[6];
    address_learning_filter_engine #(.DEPTH(8), .TICK_CYCLES(50)) u_address_learning_filter_engine (
        .clk(clk), .nrst(nrst), .frame_valid(frame_valid), .frame(frame),
        .frame_ready_ff(frame_ready_ff), .verdict_valid_ff(verdict_valid_ff),
        .verdict_ff(verdict_ff), .flt_wr(flt_wr), .flt_idx(flt_idx), .flt_mac(m[5]),
        .flt_vlan(12'h001), .flt_keep(flt_keep), .flt_done_ff(flt_done_ff),
        .age_secs(age_secs), .port_cfg(port_cfg), .stp_state(stp_state), .is_root(is_root),
        .bc_rise(16'h0004), .bc_fall(16'h0001), .link_up(link_up), .coll(coll),
        .bcast(bcast), .partition_ff(partition_ff), .part_evt_ff(part_evt_ff),
        .link_evt_ff(link_evt_ff), .topo_evt_ff(topo_evt_ff), .root_evt_ff(root_evt_ff),
        .storm_ff(storm_ff), .storm_evt_ff(storm_evt_ff));
    mac_stub u_mac_stub (.clk(clk), .link_req(link_req), .coll_port(coll_port),
        .coll_n(coll_n), .coll_go(coll_go), .link_up(link_up), .coll(coll));
    // =========================================================
    // Checking and reference model
    task chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic verdict_t model(frame_t f);
        verdict_t v;
        longint s, d;
        v = '0;
        s = f.src;
        d = f.dst;
        if (filt.exists(s) || filt.exists(d) || stp_state[f.port] != STP_FWD)
            v.drop = 1'b1;
        else if (lport.exists(d))
        begin
            if (lport[d] == f.port || lvlan[d] != f.vlan || stp_state[lport[d]] != STP_FWD)
                v.drop = 1'b1;
            else
                v.mask[lport[d]] = 1'b1;
        end
        else
        begin
            v.flood = 1'b1;
            for (int i = 0; i < NPORT; i++)
                v.mask[i] = stp_state[i] == STP_FWD && i != f.port;
        end
        if (stp_state[f.port] >= STP_LEARN && !filt.exists(s))
        begin
            lport[s] = f.port;
            lvlan[s] = f.vlan;
        end
        return v;
    endfunction
    task send(input int s, input int d, input int p, input int vl);
        frame_t f;
        verdict_t e;
        f = {m[s], m[d], 3'(p), 12'(vl)};
        frame <= f;
        frame_valid <= 1'b1;
        do @(posedge clk); while (frame_ready_ff !== 1'b1);
        frame_valid <= 1'b0;
        e = model(f);
        for (int i = 0; i < 40 && verdict_valid_ff !== 1'b1; i++)
            @(posedge clk);
        chk(16'(verdict_valid_ff), 16'h1);
        chk(verdict_ff.drop ? 16'h100 : 16'(verdict_ff), e.drop ? 16'h100 : 16'(e));
    endtask
    task flt(input logic k);
        flt_keep <= k;
        flt_wr <= 1'b1;
        do @(posedge clk); while (flt_done_ff !== 1'b1);
        flt_wr <= 1'b0;
    endtask
    task watch(input int n);
        as = '0;
        al = '0;
        ap = '0;
        at = 1'b0;
        ar = 1'b0;
        repeat (n)
        begin
            @(posedge clk);
            al |= link_evt_ff;
            ap |= part_evt_ff;
            at |= topo_evt_ff;
            ar |= root_evt_ff;
            as |= storm_evt_ff;
        end
    endtask
    task test_done;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // =========================================================
    // Clock, reset and timeout
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            fails++;
            test_done;
        end
    end
    // =========================================================
    // Scenarios
    initial
    begin
        {nrst, frame_valid, flt_wr, flt_keep, is_root, coll_go, coll_port, coll_n} = '0;
        bcast = '0;
        flt_idx = 3'h7;
        frame = '0;
        age_secs = AGE_MAX_S;
        port_cfg = '0;
        link_req = '0;
        stp_state = '1;
        for (int i = 0; i < 6; i++)
            m[i] = {$random(seed), 8'h5a, 8'(i)};
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        send(0, 1, 1, 1);
        send(1, 0, 2, 1);
        send(2, 0, 1, 1);
        send(3, 1, 3, 2);
        send(0, 3, 1, 1);
        send(3, 1, 5, 1);
        send(0, 3, 1, 1);
        stp_state[2] <= STP_BLOCK;
        send(0, 1, 1, 1);
        send(1, 4, 2, 1);
        stp_state[2] <= STP_FWD;
        repeat (6) send($unsigned($random(seed)) % 5, $unsigned($random(seed)) % 5,
            $unsigned($random(seed)) % 8, 1);
        flt(1'b1);
        filt[m[5]] = 1'b1;
        send(5, 0, 4, 1);
        send(0, 5, 1, 1);
        age_secs <= AGE_MIN_S;
        repeat (700) @(posedge clk);
        lport.delete();
        lvlan.delete();
        send(0, 1, 1, 1);
        send(5, 0, 4, 1);
        flt(1'b0);
        filt.delete(m[5]);
        send(5, 0, 4, 1);
        link_req[0] <= 1'b1;
        watch(3);
        chk(16'(al), 16'h01);
        coll_port <= 3'h0;
        coll_n <= 8'd61;
        coll_go <= 1'b1;
        watch(1);
        coll_go <= 1'b0;
        watch(130);
        chk(16'(partition_ff | ap), 16'h0);
        coll_n <= 8'd1;
        coll_go <= 1'b1;
        watch(1);
        coll_go <= 1'b0;
        watch(6);
        chk({partition_ff, ap}, 16'h0101);
        link_req[0] <= 1'b0;
        watch(3);
        chk({partition_ff, al}, 16'h0001);
        port_cfg <= 8'h20;
        stp_state[5] <= STP_LEARN;
        watch(3);
        stp_state[5] <= STP_FWD;
        watch(3);
        chk(16'(at), 16'h1);
        stp_state[5] <= STP_BLOCK;
        is_root <= 1'b1;
        watch(3);
        chk(16'({at, ar}), 16'h1);
        bcast <= 8'h01;
        watch(120);
        chk({storm_ff, as}, 16'h0101);
        bcast <= 8'h00;
        watch(120);
        chk({storm_ff, as}, 16'h0001);
        test_done;
    end
endmodule // test_address_learning_filter_engine
